// ### verilog/adcsq_regs.vh
// register map, field positions, reset values and state timing of the conversion sequencer
`ifndef ADCSQ_REGS_VH
`define ADCSQ_REGS_VH

// register indices on the plain register port
`define ADCSQ_ADDR_CSR        4'h0
`define ADCSQ_ADDR_TRG        4'h1
`define ADCSQ_ADDR_RES_BASE   4'h8

// converter control/status fields
`define ADCSQ_CSR_END         7
`define ADCSQ_CSR_IE          6
`define ADCSQ_CSR_START       5
`define ADCSQ_CSR_SCAN        4
`define ADCSQ_CSR_SPEED       3
`define ADCSQ_CSR_CHHI        2
`define ADCSQ_CSR_CHLO        0
`define ADCSQ_CSR_RESET       8'h00

// trigger control fields
`define ADCSQ_TRG_EN          7
`define ADCSQ_TRG_RSV0        0
`define ADCSQ_TRG_ONES        8'h7E
`define ADCSQ_TRG_RESET       8'h7E

// converter timing, all in states; one state is one clk_sys cycle
`define ADCSQ_DLY_MIN0        8'h06
`define ADCSQ_DLY_MIN1        8'h04
`define ADCSQ_SPL0            8'h1F
`define ADCSQ_SPL1            8'h0F
`define ADCSQ_CONV0           8'h5E
`define ADCSQ_CONV1           8'h32
`define ADCSQ_STEP0           4'h9
`define ADCSQ_STEP1           4'h5
`define ADCSQ_REARM0          8'h03
`define ADCSQ_REARM1          8'h01

// successive-approximation word
`define ADCSQ_RES_BITS        10
`define ADCSQ_SAR_MID         10'h200

`endif

// ### verilog/adcsq_sequencer.v
// conversion sequencer for a 10-bit successive-approximation converter
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "adcsq_regs.vh"
// How it works
// - 10-bit successive approximation; modes are one-shot single and repeating group scan.
// - single mode: channel code 000..111 picks input 0..7, converted once.
// - scan mode: top select bit picks input 0 or 4, low bits pick the last input of the group.
// - a write setting start while changing mode/channel starts with new settings.
// - single conversion result goes to the converted channel's result register.
// - single completion sets end flag; interrupt raised when end interrupt enabled.
// - single mode: start reads 1 while converting, hardware clears it at end.
// - scan mode: each channel result stored in its own register, in order.
// - scan: after last channel set flag, interrupt if enabled, restart group.
// - scan mode: conversion end never clears start; repeats until software or standby clears it.
// - start delay 6..9 states at speed 0, 4..5 states at speed 1.
// - sampling lasts 31 states at speed 0, 15 states at speed 1.
// - first conversion totals 131..134 states at speed 0, 69..70 at speed 1.
// - later scan conversions take fixed 128 states or 66 states.
// - with trigger enable set, the selected trigger pin edge sets start.
// - trigger edge polarity comes from an edge-select bit outside this block.
// - triggered conversions behave exactly like software-started ones.
// - trigger control bits 6..1 are reserved and read as 1.
// - end flag clears only by writing 0 after reading it as 1.
// - reset or standby clears start and stops any scan.
// - speed select 0 gives at most 134 states, 1 at most 70.

module adcsq_sequencer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // register port
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWrStb,
  input  wire        regRdStb,
  output reg  [15:0] regRdData,
  // system and trigger
  input  wire        standbyReq,
  input  wire        trigEdgeRise,
  input  wire        extTrigPin,
  // analog front end
  input  wire        compHigh,
  output reg  [2:0]  analogSel,
  output reg         sampleEn,
  output reg  [9:0]  sarTrial,
  // interrupt request
  output reg         convEndIrq
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [4:0] ST_IDLE   = 5'b00001;
  localparam [4:0] ST_DELAY  = 5'b00010;
  localparam [4:0] ST_SAMPLE = 5'b00100;
  localparam [4:0] ST_CONV   = 5'b01000;
  localparam [4:0] ST_REARM  = 5'b10000;

  localparam [7:0] SPL0_CYC  = `ADCSQ_SPL0;
  localparam [7:0] SPL1_CYC  = `ADCSQ_SPL1;
  localparam [7:0] CONV0_CYC = `ADCSQ_CONV0;
  localparam [7:0] CONV1_CYC = `ADCSQ_CONV1;
  localparam [3:0] STEP0_CYC = `ADCSQ_STEP0;
  localparam [3:0] STEP1_CYC = `ADCSQ_STEP1;
  localparam [7:0] RARM0_CYC = `ADCSQ_REARM0;
  localparam [7:0] RARM1_CYC = `ADCSQ_REARM1;
  localparam [7:0] DMIN0_CYC = `ADCSQ_DLY_MIN0;
  localparam [7:0] DMIN1_CYC = `ADCSQ_DLY_MIN1;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  reg        endFlag;
  reg        endIe;
  reg        startBit;
  reg        scanMode;
  reg        speedSel;
  reg [2:0]  chanSel;
  reg        trigEn;
  reg        trigRsv0;
  reg        endReadArmed;
  reg [9:0]  resultMem [0:7];

  // sequencer state
  reg [4:0]  state;
  reg [7:0]  cnt;
  reg [3:0]  stepCnt;
  reg [3:0]  bitIdx;
  reg [2:0]  curChan;
  reg [1:0]  divPhase;

  // pin synchronisers
  wire       trigSync2;
  reg        trigPrev;
  wire       compSync2;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire csrWr = regWrStb && (regAddr == `ADCSQ_ADDR_CSR);
  wire trgWr = regWrStb && (regAddr == `ADCSQ_ADDR_TRG);
  wire csrRd = regRdStb && (regAddr == `ADCSQ_ADDR_CSR);

  // edge polarity is owned by the external edge-select bit
  wire trigEdge = trigEdgeRise ? (trigSync2 & ~trigPrev)
                               : (~trigSync2 & trigPrev);
  wire trigFire = trigEn && trigEdge;

  wire [2:0] grpFirst = {chanSel[2], 2'b00};
  wire [2:0] grpLast  = chanSel;

  // conversion steps
  wire [7:0] splLoad  = speedSel ? (SPL1_CYC - 8'h01) : (SPL0_CYC - 8'h01);
  wire [7:0] convLoad = speedSel ? (CONV1_CYC - 8'h01) : (CONV0_CYC - 8'h01);
  wire [3:0] stepLoad = speedSel ? (STEP1_CYC - 4'h1) : (STEP0_CYC - 4'h1);
  wire [7:0] rarmLoad = speedSel ? (RARM1_CYC - 8'h01) : (RARM0_CYC - 8'h01);
  // idle cycle of the start counts as one delay state; divider phase adds the rest
  wire [7:0] dlyLoad  = speedSel
                        ? (DMIN1_CYC - 8'h02 + {7'h00, ~divPhase[0]})
                        : (DMIN0_CYC - 8'h02 + {6'h00, ~divPhase});

  ////////////////////////////////////////////////////////////////////////////
  // successive approximation next word
  reg [9:0] next_sar;
  reg       stepDone;
  always @* begin
    next_sar = sarTrial;
    stepDone = 1'b0;
    if (state == ST_CONV && stepCnt == 4'h0 && bitIdx != 4'hF) begin
      stepDone = 1'b1;
      if (!compSync2) begin
        next_sar[bitIdx] = 1'b0;
      end
      if (bitIdx != 4'h0) begin
        next_sar[bitIdx - 4'h1] = 1'b1;
      end
    end
  end

  wire convLast   = (state == ST_CONV) && (cnt == 8'h00);
  wire scanWrap   = scanMode && (curChan == grpLast);
  wire hwSetEnd   = convLast && (!scanMode || scanWrap);
  wire swClearEnd = csrWr && endReadArmed && !regWrData[`ADCSQ_CSR_END];

  // set wins over a clear that arrives in the same cycle
  wire next_endFlag = hwSetEnd | (endFlag & ~swClearEnd);

  // an enable written beside the flag counts at once, so the request never lags it
  wire next_irqEn   = csrWr ? regWrData[`ADCSQ_CSR_IE] : endIe;

  // start bit: software write, trigger, hardware clear, standby
  reg next_startBit;
  always @* begin
    next_startBit = startBit;
    if (csrWr) begin
      next_startBit = regWrData[`ADCSQ_CSR_START];
    end
    if (convLast && !scanMode) begin
      next_startBit = 1'b0;
    end
    if (trigFire) begin
      next_startBit = 1'b1;
    end
    if (standbyReq) begin
      next_startBit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and divider phase
  // trigger chain resets high so an idle-high pin gives no edge out of reset
  adcsq_sync2 #(
    .RESET_VAL (1'b1)
  ) u_trig_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pinIn   (extTrigPin),
    .pinSync (trigSync2)
  );

  adcsq_sync2 #(
    .RESET_VAL (1'b0)
  ) u_comp_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pinIn   (compHigh),
    .pinSync (compSync2)
  );

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      trigPrev <= 1'b1;
      divPhase <= 2'h0;
    end else begin
      trigPrev <= trigSync2;
      divPhase <= divPhase + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      endFlag      <= 1'b0;
      endIe        <= 1'b0;
      startBit     <= 1'b0;
      scanMode     <= 1'b0;
      speedSel     <= 1'b0;
      chanSel      <= 3'h0;
      trigEn       <= 1'b0;
      trigRsv0     <= 1'b0;
      endReadArmed <= 1'b0;
      convEndIrq   <= 1'b0;
    end else begin
      endFlag  <= next_endFlag;
      startBit <= next_startBit;
      if (csrWr) begin
        // mode and channel take effect together with the start bit
        endIe    <= regWrData[`ADCSQ_CSR_IE];
        scanMode <= regWrData[`ADCSQ_CSR_SCAN];
        speedSel <= regWrData[`ADCSQ_CSR_SPEED];
        chanSel  <= regWrData[`ADCSQ_CSR_CHHI:`ADCSQ_CSR_CHLO];
      end
      if (trgWr) begin
        trigEn   <= regWrData[`ADCSQ_TRG_EN];
        trigRsv0 <= regWrData[`ADCSQ_TRG_RSV0];
      end
      if (csrRd && endFlag) begin
        endReadArmed <= 1'b1;
      end else if (csrWr) begin
        // a control write drops the arming unless a read of the set flag comes in the same cycle; the flag must be read as set again
        endReadArmed <= 1'b0;
      end
      convEndIrq <= next_endFlag & next_irqEn;
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      regRdData <= 16'h0000;
    end else if (regRdStb) begin
      if (regAddr == `ADCSQ_ADDR_CSR) begin
        regRdData <= {8'h00, endFlag, endIe, startBit, scanMode, speedSel, chanSel};
      end else if (regAddr == `ADCSQ_ADDR_TRG) begin
        regRdData <= {8'h00, trigEn, 6'h3F, trigRsv0};
      end else if (regAddr[3]) begin
        // a channel never converted since power-up reads unknown
        regRdData <= {6'h00, resultMem[regAddr[2:0]]};
      end else begin
        regRdData <= 16'h0000;
      end
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // result registers; no reset so they can map onto a small array
  always @(posedge clk_sys) begin
    if (convLast) begin
      resultMem[curChan] <= next_sar;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      cnt       <= 8'h00;
      stepCnt   <= 4'h0;
      bitIdx    <= 4'hF;
      curChan   <= 3'h0;
      analogSel <= 3'h0;
      sampleEn  <= 1'b0;
      sarTrial  <= 10'h000;
    end else if (!startBit) begin
      // clearing start stops whatever is running
      state    <= ST_IDLE;
      sampleEn <= 1'b0;
      bitIdx   <= 4'hF;
    end else begin
      sarTrial <= next_sar;
      case (state)
        ST_IDLE: begin
          state   <= ST_DELAY;
          cnt     <= dlyLoad;
          curChan <= scanMode ? grpFirst : chanSel;
        end
        ST_DELAY: begin
          analogSel <= curChan;
          if (cnt == 8'h00) begin
            state    <= ST_SAMPLE;
            cnt      <= splLoad;
            sampleEn <= 1'b1;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_SAMPLE: begin
          if (cnt == 8'h00) begin
            state    <= ST_CONV;
            cnt      <= convLoad;
            stepCnt  <= stepLoad;
            bitIdx   <= 4'h9;
            sampleEn <= 1'b0;
            sarTrial <= `ADCSQ_SAR_MID;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_CONV: begin
          // decision comes from the synchronised comparator, settled well before step end
          if (stepDone) begin
            stepCnt <= stepLoad;
            bitIdx  <= bitIdx - 4'h1;
          end else if (stepCnt != 4'h0) begin
            stepCnt <= stepCnt - 4'h1;
          end
          if (cnt == 8'h00) begin
            bitIdx <= 4'hF;
            if (scanMode) begin
              state   <= ST_REARM;
              cnt     <= rarmLoad;
              curChan <= scanWrap ? grpFirst : (curChan + 3'h1);
            end else begin
              state <= ST_IDLE;
            end
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_REARM: begin
          // no start delay between scan channels, only a short settle gap
          analogSel <= curChan;
          if (cnt == 8'h00) begin
            state    <= ST_SAMPLE;
            cnt      <= splLoad;
            sampleEn <= 1'b1;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // adcsq_sequencer

////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser; only the second flop may be read by other logic
module adcsq_sync2 #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire clk_sys,
  input  wire rst_b,
  // pin and its synchronised copy
  input  wire pinIn,
  output reg  pinSync
);

  reg pinMeta;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pinMeta <= RESET_VAL;
      pinSync <= RESET_VAL;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

endmodule // adcsq_sync2

// ### bench/adcsq_analog_model.sv
// analog front-end model: one fixed level per input, compared with the trial word
`timescale 1ns/1ps
module adcsq_analog_model (
  // level setting
  input  wire [9:0] lvlBase,
  // converter side
  input  wire [2:0] analogSel,
  input  wire [9:0] sarTrial,
  output wire       compHigh
);
  wire [9:0] level;
  // distinct level per input so a wrong channel shows as a wrong word
  assign level    = lvlBase + {1'b0, analogSel, 6'h00} + {7'h00, analogSel};
  assign compHigh = (level >= sarTrial);
endmodule // adcsq_analog_model

// ### bench/adcsq_sequencer_properties.sv
// port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module adcsq_sequencer_properties (
  // clock and reset
  input wire        clk_sys,
  input wire        rst_b,
  // register port
  input wire [3:0]  regAddr,
  input wire [15:0] regWrData,
  input wire        regWrStb,
  input wire        regRdStb,
  input wire [15:0] regRdData,
  // system and trigger
  input wire        standbyReq,
  input wire        trigEdgeRise,
  input wire        extTrigPin,
  // analog front end
  input wire        compHigh,
  input wire [2:0]  analogSel,
  input wire        sampleEn,
  input wire [9:0]  sarTrial,
  input wire        convEndIrq
);
  reg [5:0] sampLen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (!rst_b || !sampleEn) begin
      sampLen <= 6'h00;
    end else begin
      sampLen <= sampLen + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(regRdStb) |-> regRdData == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rd_trg;
    regRdStb && regAddr == 4'h1 |=> regRdData[15:8] == 8'h00 && regRdData[6:1] == 6'h3F;
  endproperty
  a_rd_trg: assert property (p_rd_trg) else $error("reserved bits not ones");
  property p_rd_gap;
    regRdStb && regAddr >= 4'h2 && regAddr <= 4'h7 |=> regRdData == 16'h0000;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
  property p_rst_quiet;
    $rose(rst_b) |-> !sampleEn && !convEndIrq && sarTrial == 10'h000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_samp_len;
    $fell(sampleEn) |-> sampLen == 6'h0F || sampLen == 6'h1F;
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sampling length wrong");
  property p_samp_max;
    sampleEn |-> sampLen <= 6'h1E;
  endproperty
  a_samp_max: assert property (p_samp_max) else $error("sampling too long");
  property p_sel_hold;
    sampleEn && $past(sampleEn) |-> $stable(analogSel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("input moved while sampling");
  property p_sar_mid;
    $fell(sampleEn) |-> ##[0:2] sarTrial == 10'h200;
  endproperty
  a_sar_mid: assert property (p_sar_mid) else $error("first trial not midscale");
  property p_irq_fall;
    $fell(convEndIrq) |-> $past(regWrStb) || $past(regWrStb, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
  property p_standby;
    standbyReq |-> ##[1:2] !sampleEn;
  endproperty
  a_standby: assert property (p_standby) else $error("sampling during standby");
endmodule // adcsq_sequencer_properties

bind adcsq_sequencer adcsq_sequencer_properties u_props (
  .clk_sys, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .standbyReq,
  .trigEdgeRise, .extTrigPin, .compHigh, .analogSel, .sampleEn, .sarTrial, .convEndIrq
);

// ### bench/adcsq_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adcsq_sequencer_bench;
  reg         clk_sys;
  reg         rst_b;
  reg  [3:0]  regAddr;
  reg  [15:0] regWrData;
  reg         regWrStb;
  reg         regRdStb;
  reg         standbyReq;
  reg         trigEdgeRise;
  reg         extTrigPin;
  wire [15:0] regRdData;
  wire        compHigh;
  wire [2:0]  analogSel;
  wire        sampleEn;
  wire [9:0]  sarTrial;
  wire        convEndIrq;
  reg  [15:0] rdv;
  integer     failures;
  integer     samplesChecked;
  integer     n;
  integer     i;
  integer     tMin;
  integer     tMax;
  integer     tPer;
  ////////////////////////////////////////////////////////////
  adcsq_sequencer u_dut (
    .clk_sys, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .standbyReq,
    .trigEdgeRise, .extTrigPin, .compHigh, .analogSel, .sampleEn, .sarTrial, .convEndIrq
  );
  adcsq_analog_model u_front (.lvlBase(10'h0A3), .analogSel, .sarTrial, .compHigh);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input [15:0] seen, input [15:0] exp);
    samplesChecked = samplesChecked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function [15:0] lvl(input [2:0] ch);
    lvl = 16'h00A3 + 16'h0041 * ch;
  endfunction
  task wr(input [3:0] a, input [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
    // one idle edge so a following call never drives the strobe twice in one step
    @(posedge clk_sys);
  endtask
  task rd(input [3:0] a, output [15:0] d);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    @(posedge clk_sys);
    d = regRdData;
  endtask
  // back-to-back status reads; n ends two past the edge where the state changed
  task poll(input [7:0] mask, input [7:0] val);
    regAddr <= 4'h0;
    regRdStb <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    do begin
      @(posedge clk_sys);
      n = n + 1;
    end while ((regRdData[7:0] & mask) !== val && n < 700);
    regRdStb <= 1'b0;
    rdv = regRdData;
    @(posedge clk_sys);
    if (n >= 700) begin
      failures = failures + 1;
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////
  task tRegs;
    rd(4'h0, rdv);
    check(rdv, 16'h0000);
    rd(4'h1, rdv);
    check(rdv, 16'h007E);
    wr(4'h5, 16'h00FF);
    rd(4'h5, rdv);
    check(rdv, 16'h0000);
    wr(4'h1, 16'h0080); // reserved bit 0 left clear
    rd(4'h1, rdv);
    check(rdv, 16'h00FE);
    wr(4'h1, 16'h0000);
  endtask
  task tSingle(input spd, input [2:0] ch, input ie);
    wr(4'h0, {9'h000, ie, 1'b1, 1'b0, spd, ch});
    poll(8'h20, 8'h00);
    check(n >= (spd ? 69 : 131) && n <= (spd ? 70 : 134), 16'h0001);
    check(rdv & 16'h00A0, 16'h0080);
    check({15'h0000, convEndIrq}, {15'h0000, ie});
    rd({1'b1, ch}, rdv);
    check(rdv, lvl(ch));
  endtask
  task tFlag;
    wr(4'h0, 16'h00C0);
    wr(4'h0, 16'h0040);
    rd(4'h0, rdv);
    check(rdv, 16'h00C0);
    wr(4'h0, 16'h0040);
    rd(4'h0, rdv);
    check(rdv, 16'h0040);
    check({15'h0000, convEndIrq}, 16'h0000);
  endtask
  task tScan(input spd, input [2:0] code);
    tMin = spd ? 69 : 131;
    tMax = spd ? 70 : 134;
    tPer = spd ? 66 : 128;
    wr(4'h0, {10'h000, 2'b11, spd, code});
    poll(8'h80, 8'h80);
    check(n >= tMin + tPer * code[1:0] && n <= tMax + tPer * code[1:0], 16'h0001);
    check(rdv & 16'h0020, 16'h0020);
    for (i = 0; i <= code[1:0]; i = i + 1) begin
      rd({1'b1, code[2], i[1:0]}, rdv);
      check(rdv, lvl({code[2], i[1:0]}));
    end
    wr(4'h0, {10'h000, 2'b11, spd, code});
    poll(8'h80, 8'h80);
    check(n <= tPer * (code[1:0] + 1), 16'h0001);
    // stop only once the next sampling window has closed
    repeat (spd ? 20 : 40) @(posedge clk_sys);
    wr(4'h0, {10'h000, 2'b01, spd, code});
    repeat (150) @(posedge clk_sys);
    rd(4'h0, rdv);
    check(rdv, {10'h000, 2'b01, spd, code});
  endtask
  task tTrig(input rise);
    trigEdgeRise <= rise;
    extTrigPin <= ~rise;
    wr(4'h1, 16'h0080);
    wr(4'h0, 16'h000A);
    repeat (8) @(posedge clk_sys);
    rd(4'h0, rdv);
    check(rdv, 16'h000A);
    extTrigPin <= rise;
    poll(8'h20, 8'h20);
    check(n <= 8, 16'h0001);
    poll(8'h20, 8'h00);
    rd(4'hA, rdv);
    check(rdv, lvl(3'h2));
    wr(4'h1, 16'h0000);
  endtask
  task tStandby;
    wr(4'h0, 16'h0023);
    repeat (60) @(posedge clk_sys);
    standbyReq <= 1'b1;
    @(posedge clk_sys);
    standbyReq <= 1'b0;
    repeat (150) @(posedge clk_sys);
    rd(4'h0, rdv);
    check(rdv, 16'h0003);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    samplesChecked = 0;
    rst_b = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    standbyReq = 1'b0;
    trigEdgeRise = 1'b0;
    extTrigPin = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    tRegs();
    for (i = 0; i < 8; i = i + 1) tSingle(1'b1, i[2:0], i[0]);
    tSingle(1'b0, 3'h5, 1'b1);
    tFlag();
    tScan(1'b1, 3'h3);
    tScan(1'b1, 3'h5);
    tScan(1'b1, 3'h7);
    tScan(1'b0, 3'h0);
    tTrig(1'b1);
    tTrig(1'b0);
    tStandby();
    conclude();
  end
endmodule // adcsq_sequencer_bench
